/* logic/tcvs_pkg.sv */
package tcvs_pkg;
  localparam int TCVS_NCH = 6;
  localparam int TCVS_VAL_W = 16;
  // byte addresses: value registers at 0x10 + 8*i
  localparam logic [7:0] TCVS_CV_BASE = 8'h10;
  localparam logic [7:0] TCVS_CV_STRIDE = 8'h08;
  localparam logic [7:0] TCVS_STATUS_OFS = 8'h50;
  localparam logic [7:0] TCVS_CSC_BASE = 8'h60;
  localparam logic [7:0] TCVS_MODE_OFS = 8'h80;
  localparam logic [7:0] TCVS_IRQ_STAT_OFS = 8'h84;
  localparam logic [7:0] TCVS_IRQ_CLR_OFS = 8'h88;
  localparam logic [7:0] TCVS_IRQ_EN_OFS = 8'h8C;
  localparam int TCVS_WRAP_BIT = 8;
  localparam int TCVS_CSC_FLAG_BIT = 7;
  localparam logic [31:0] TCVS_CV_RESET = 32'h00000000;
  localparam logic [31:0] TCVS_ERR_DATA = 32'h00000000;
endpackage

/* logic/tcvs_chan_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface tcvs_chan_if #(parameter int W = 16);
  logic wr;
  logic [W-1:0] wdata;
  logic input_mode;
  logic capture;
  logic [W-1:0] counter;
  logic update;
  logic [W-1:0] value;
  modport ctrl (output wr, output wdata, output input_mode, output capture,
    output counter, output update, input value);
  modport chan (input wr, input wdata, input input_mode, input capture,
    input counter, input update, output value);
endinterface
`default_nettype wire

/* logic/tcvs_chan_value.sv */
`timescale 1ns/1ns
`default_nettype none
module tcvs_chan_value
  import tcvs_pkg::*;
#(
  parameter int W = TCVS_VAL_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // channel side
  tcvs_chan_if.chan ch
);
  logic [W-1:0] value_reg;
  logic [W-1:0] buf_reg;
  logic pend_reg;

  // compare writes wait in the buffer until the update point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_reg <= '0;
      pend_reg <= 1'b0;
    end else if (ch.wr && !ch.input_mode) begin
      buf_reg <= ch.wdata;
      pend_reg <= 1'b1;
    end else if (ch.update || ch.input_mode) begin
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_reg <= TCVS_CV_RESET[W-1:0];
    end else if (ch.input_mode) begin
      if (ch.capture) begin
        value_reg <= ch.counter;
      end
    end else if (ch.update && pend_reg) begin
      value_reg <= buf_reg;
    end
  end

  assign ch.value = value_reg;

  chk_capture_loads: assert property (@(posedge pclk) disable iff (!presetn)
    ch.input_mode && ch.capture |=> value_reg == $past(ch.counter))
    else $error("capture value not loaded");
  chk_input_write_drop: assert property (@(posedge pclk) disable iff (!presetn)
    ch.input_mode && !ch.capture |=> $stable(value_reg))
    else $error("value changed in input mode without capture");
  chk_no_early_match: assert property (@(posedge pclk) disable iff (!presetn)
    !ch.input_mode && !ch.update |=> $stable(value_reg))
    else $error("match value changed outside update point");
  chk_buffer_holds: assert property (@(posedge pclk) disable iff (!presetn)
    ch.wr && !ch.input_mode |=> buf_reg == $past(ch.wdata))
    else $error("compare write not buffered");
endmodule // tcvs_chan_value
`default_nettype wire

/* logic/tcvs_top.sv */
// Functional notes
// - value holds capture or match value by mode
// - writes ignored in input capture mode
// - compare writes go to per-channel buffer
// - buffer moves to value at update point
// - 16-bit value, upper bits read zero
// - combined register mirrors each channel flag
// - one read returns all channel flags
// - writing all ones clears all flags
// - hardware sets flag on every channel event
// - only a written one clears a flag
// - new event beats a clearing write
// - channel interrupt request never lost
// - bit 8 mirrors counter wrap flag
// - bits 0 to 5 hold channel flags
// - bits 31:9 and 7:6 read zero
`timescale 1ns/1ns
`default_nettype none
module tcvs_top
  import tcvs_pkg::*;
#(
  parameter int NCH = TCVS_NCH,
  parameter int W = TCVS_VAL_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer core
  input wire logic [W-1:0] counter_value,
  input wire logic [NCH-1:0] chan_event,
  input wire logic wrap_event,
  input wire logic update_point,
  // channel match values to the compare logic
  output logic [NCH*W-1:0] match_values,
  // interrupt
  output logic irq
);
  // refused at elaboration: flag map and value field have fixed widths
  if (NCH < 1 || NCH > 6) begin : g_bad_nch
    $error("NCH must be 1 to 6");
  end
  if (W != 16) begin : g_bad_w
    $error("W must be 16");
  end

  logic wr_acc;
  logic rd_acc;
  logic full_word;
  logic [NCH-1:0] mode_input_reg;
  logic [NCH-1:0] chan_flag_reg;
  logic [NCH-1:0] flag_clr;
  logic wrap_flag_reg;
  logic wrap_clr;
  logic [NCH:0] irq_stat_reg;
  logic [NCH:0] irq_en_reg;
  logic [NCH:0] irq_stat_next;
  logic [NCH:0] irq_events;
  logic [NCH-1:0] cv_hit;
  logic [NCH-1:0] csc_hit;
  logic [NCH-1:0] cv_wr;
  logic [W-1:0] cv_val [NCH];
  logic [31:0] rdata_next;
  logic addr_ok;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !pwrite;
  // partial byte updates of a value are refused
  assign full_word = pstrb[0] && pstrb[1];

  // zero wait state slave
  assign pready = 1'b1;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_chan
      tcvs_chan_if #(.W(W)) chif ();
      assign cv_hit[gi] = paddr == 8'(TCVS_CV_BASE + 8'(gi) * TCVS_CV_STRIDE);
      assign csc_hit[gi] = paddr == 8'(TCVS_CSC_BASE + 8'(gi * 4));
      assign cv_wr[gi] = wr_acc && cv_hit[gi] && full_word;
      assign chif.wr = cv_wr[gi] && !mode_input_reg[gi];
      assign chif.wdata = pwdata[W-1:0];
      assign chif.input_mode = mode_input_reg[gi];
      assign chif.capture = chan_event[gi];
      assign chif.counter = counter_value;
      assign chif.update = update_point;
      assign cv_val[gi] = chif.value;
      assign match_values[gi*W +: W] = chif.value;
      tcvs_chan_value #(.W(W)) u_val (
        .pclk(pclk),
        .presetn(presetn),
        .ch(chif.chan)
      );
      // either view clears the same flag
      assign flag_clr[gi] = wr_acc && pwdata[gi] && (paddr == TCVS_STATUS_OFS)
        || wr_acc && pwdata[TCVS_CSC_FLAG_BIT] && csc_hit[gi];
    end
  endgenerate

  assign wrap_clr = wr_acc && (paddr == TCVS_STATUS_OFS) && pwdata[TCVS_WRAP_BIT];

  // mode register: bit i high puts channel i in input capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_input_reg <= '0;
    end else if (wr_acc && paddr == TCVS_MODE_OFS) begin
      mode_input_reg <= pwdata[NCH-1:0];
    end
  end

  // set wins over clear so a late event survives the clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_flag_reg <= '0;
    end else begin
      chan_flag_reg <= chan_event | (chan_flag_reg & ~flag_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_flag_reg <= 1'b0;
    end else begin
      wrap_flag_reg <= wrap_event | (wrap_flag_reg & ~wrap_clr);
    end
  end

  // interrupt status: sticky, cleared through the clear register
  assign irq_events = {wrap_event, chan_event};
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_acc && paddr == TCVS_IRQ_CLR_OFS) begin
      irq_stat_next = irq_stat_next & ~pwdata[NCH:0];
    end
    irq_stat_next = irq_stat_next | irq_events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= '0;
    end else if (wr_acc && paddr == TCVS_IRQ_EN_OFS) begin
      irq_en_reg <= pwdata[NCH:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_next & irq_en_reg);
    end
  end

  // read mux
  always_comb begin
    rdata_next = 32'h00000000;
    addr_ok = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (cv_hit[i]) begin
        rdata_next = {16'h0000, cv_val[i]};
        addr_ok = 1'b1;
      end
      if (csc_hit[i]) begin
        rdata_next[TCVS_CSC_FLAG_BIT] = chan_flag_reg[i];
        addr_ok = 1'b1;
      end
    end
    if (paddr == TCVS_STATUS_OFS) begin
      rdata_next[NCH-1:0] = chan_flag_reg;
      rdata_next[TCVS_WRAP_BIT] = wrap_flag_reg;
      addr_ok = 1'b1;
    end
    if (paddr == TCVS_MODE_OFS) begin
      rdata_next[NCH-1:0] = mode_input_reg;
      addr_ok = 1'b1;
    end
    if (paddr == TCVS_IRQ_STAT_OFS) begin
      rdata_next[NCH:0] = irq_stat_reg;
      addr_ok = 1'b1;
    end
    if (paddr == TCVS_IRQ_EN_OFS) begin
      rdata_next[NCH:0] = irq_en_reg;
      addr_ok = 1'b1;
    end
    if (paddr == TCVS_IRQ_CLR_OFS) begin
      addr_ok = 1'b1;
    end
  end

  // data captured in setup, stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= rd_acc ? rdata_next : 32'h00000000;
      pslverr <= !addr_ok;
    end
  end

  chk_set_beats_clear: assert property (@(posedge pclk) disable iff (!presetn)
    chan_event[0] && flag_clr[0] |=> chan_flag_reg[0])
    else $error("event lost against clear");
  chk_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
    chan_event != '0 |=> (chan_flag_reg & $past(chan_event)) == $past(chan_event))
    else $error("flag not set on event");
  chk_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    flag_clr == '0 && chan_event == '0 |=> chan_flag_reg == $past(chan_flag_reg))
    else $error("flag changed without clear");
  chk_all_ones_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == TCVS_STATUS_OFS && pwdata[NCH-1:0] == '1 && chan_event == '0
    |=> chan_flag_reg == '0)
    else $error("all ones did not clear flags");
  chk_status_read: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == TCVS_STATUS_OFS
    |=> prdata == {23'h0, $past(wrap_flag_reg), 2'b00, 6'($past(chan_flag_reg))})
    else $error("status read wrong");
  chk_wrap_mirror: assert property (@(posedge pclk) disable iff (!presetn)
    wrap_event |=> wrap_flag_reg ##0 irq_stat_reg[NCH])
    else $error("wrap flag not mirrored");
  chk_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && cv_hit != '0 |=> prdata[31:16] == 16'h0000)
    else $error("value upper bits not zero");
  chk_irq_kept: assert property (@(posedge pclk) disable iff (!presetn)
    chan_event[0] && irq_en_reg[0] && $stable(irq_en_reg) |=> irq)
    else $error("interrupt lost");
  chk_csc_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && csc_hit[0] && pwdata[TCVS_CSC_FLAG_BIT] && !chan_event[0]
    |=> !chan_flag_reg[0])
    else $error("csc view clear failed");
  chk_csc_mirror: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && csc_hit[0]
    |=> prdata == {24'h000000, $past(chan_flag_reg[0]), 7'h00})
    else $error("csc view does not mirror flag");
endmodule // tcvs_top
`default_nettype wire

/* tb/tcvs_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tcvs_tb_top import tcvs_pkg::*; ();
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [15:0] counter_value = 16'h0000;
  logic [5:0] chan_event = 6'h00;
  logic wrap_event = 1'b0;
  logic update_point = 1'b0;
  logic [95:0] match_values;
  logic [31:0] q;
  logic e;
  int num_errors = 0;
  int samples_checked = 0;

  always #10 pclk = ~pclk;

  tcvs_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .counter_value(counter_value),
    .chan_event(chan_event), .wrap_event(wrap_event), .update_point(update_point),
    .match_values(match_values), .irq(irq));

  task automatic finish_test();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ev rides on the access cycle so an event can meet a clearing write
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [5:0] ev, output logic [31:0] r, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    chan_event <= ev;
    n = 0;
    do begin
      @(posedge pclk);
      chan_event <= 6'h00;
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      finish_test();
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF, 6'h00, q, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000, 4'hF, 6'h00, q, e);
    check(q, exp);
  endtask

  task automatic pulse(input logic [5:0] ev, input logic w, input logic u);
    @(posedge pclk);
    chan_event <= ev;
    wrap_event <= w;
    update_point <= u;
    @(posedge pclk);
    chan_event <= 6'h00;
    wrap_event <= 1'b0;
    update_point <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  function automatic logic [7:0] cv(input int i);
    return 8'(TCVS_CV_BASE + TCVS_CV_STRIDE * i);
  endfunction

  task automatic t_buffer();
    for (int i = 0; i < 6; i++) begin
      rdchk(cv(i), TCVS_CV_RESET);
      wr(cv(i), 32'hFFFFA000 + i);
      rdchk(cv(i), TCVS_CV_RESET);
    end
    // a single-byte write must not land
    apb(1'b1, cv(0), 32'h00005555, 4'h1, 6'h00, q, e);
    pulse(6'h00, 1'b0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      rdchk(cv(i), 32'h0000A000 + i);
      check({16'h0000, match_values[16*i +: 16]}, 32'h0000A000 + i);
    end
  endtask

  task automatic t_capture();
    wr(TCVS_MODE_OFS, 32'h00000002);
    counter_value <= 16'hBEEF;
    pulse(6'h02, 1'b0, 1'b0);
    rdchk(cv(1), 32'h0000BEEF);
    wr(cv(1), 32'h00001234);
    pulse(6'h00, 1'b0, 1'b1);
    rdchk(cv(1), 32'h0000BEEF);
    wr(TCVS_MODE_OFS, 32'h00000000);
  endtask

  task automatic t_flags();
    wr(TCVS_STATUS_OFS, 32'h0000003F);
    pulse(6'h3F, 1'b1, 1'b0);
    rdchk(TCVS_STATUS_OFS, 32'h0000013F);
    wr(TCVS_STATUS_OFS, 32'h00000000);
    rdchk(TCVS_STATUS_OFS, 32'h0000013F);
    for (int i = 0; i < 6; i++) begin
      rdchk(8'(TCVS_CSC_BASE + 4 * i), 32'h00000080);
    end
    wr(8'(TCVS_CSC_BASE + 8), 32'h00000080);
    rdchk(TCVS_STATUS_OFS, 32'h0000013B);
    wr(TCVS_STATUS_OFS, 32'hFFFFFEFF);
    rdchk(TCVS_STATUS_OFS, 32'h00000100);
    pulse(6'h08, 1'b0, 1'b0);
    apb(1'b1, TCVS_STATUS_OFS, 32'h00000008, 4'hF, 6'h08, q, e);
    rdchk(TCVS_STATUS_OFS, 32'h00000108);
    wr(TCVS_STATUS_OFS, 32'h00000008);
    rdchk(TCVS_STATUS_OFS, 32'h00000100);
  endtask

  task automatic t_irq();
    wr(TCVS_IRQ_CLR_OFS, 32'h0000007F);
    wr(TCVS_IRQ_EN_OFS, 32'h00000001);
    pulse(6'h02, 1'b0, 1'b0);
    check({31'h0, irq}, 32'h0);
    pulse(6'h01, 1'b0, 1'b0);
    check({31'h0, irq}, 32'h1);
    rdchk(TCVS_IRQ_STAT_OFS, 32'h00000003);
    apb(1'b1, TCVS_IRQ_CLR_OFS, 32'h00000001, 4'hF, 6'h01, q, e);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    wr(TCVS_IRQ_CLR_OFS, 32'h0000007F);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
  endtask

  // reset in mid-run must drop flags, values and the interrupt
  task automatic t_reset();
    pulse(6'h01, 1'b1, 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    check(match_values[31:0], 32'h00000000);
    presetn <= 1'b1;
    rdchk(TCVS_STATUS_OFS, 32'h00000000);
  endtask

  task automatic t_unmapped();
    apb(1'b0, 8'hF0, 32'h00000000, 4'hF, 6'h00, q, e);
    check({31'h0, e}, 32'h1);
    check(q, TCVS_ERR_DATA);
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_buffer();
    t_capture();
    t_flags();
    t_irq();
    t_unmapped();
    t_reset();
    finish_test();
  end
endmodule // tcvs_tb_top
`default_nettype wire
